// ---- logic/cies_core.sv ----
// Summary of operation
// - Decimal adjust adds six to low nibble if above nine or digit-carry.
// - High nibble always gets plus digit-carry, then plus six if that sum is above nine or carry.
// - Decimal adjust is one word, one cycle, and changes only accumulator and carry.
// - Decrement file register; destination bit picks accumulator or file.
// - Bank bit zero uses access bank, else bank select register.
// - Extended set, access bit zero, address up to 95: indexed offset.
// - Accumulator call pushes counter plus two, loads counter from latches.
// - Accumulator call takes two cycles; no accumulator or status change.
// - Indexed move: pointer plus 7-bit offset to 12-bit address.
// - Move addresses span the whole 4096-byte data space.
`default_nettype none
module cies_core
	import cies_pkg::*;
(
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	// Instruction fetch
	input  wire logic                 instr_valid,
	input  wire logic [15:0]          instr_word,
	output logic                      instr_ready,
	// Data memory, read data returns one cycle after rd
	output cies_dbus_type             dbus_ff,
	input  wire logic [7:0]           dbus_rdata,
	// Core context
	input  wire logic                 ext_set_en,
	input  wire logic [3:0]           bank_select_reg,
	input  wire logic [11:0]          third_file_select_pointer,
	input  wire logic [7:0]           counter_high_latch,
	input  wire logic [4:0]           counter_upper_latch,
	input  wire logic [CIES_PC_W-1:0] pc_in,
	// Architectural state out
	output logic [7:0]                accumulator_register_ff,
	output cies_flags_type            flags_ff,
	output logic [CIES_PC_W-1:0]      pc_ff,
	output logic                      pc_load_ff,
	output logic [CIES_PC_W-1:0]      stack_top,
	output logic                      busy,
	output logic                      illegal_ff
);

	// ****************************************************************
	// Decode
	// ****************************************************************
	cies_state_type state_ff;
	cies_state_type nxt_state;
	logic [15:0]    op_ff;
	logic [11:0]    addr_ff;
	logic [11:0]    dec_addr;
	logic           is_adj;
	logic           is_call;
	logic           is_decr;
	logic           is_move;
	logic           data_due_ff;
	logic           exec_go;

	// Decoder only ever looks at the first word
	assign is_adj  = instr_word == CIES_OP_DECADJ;
	assign is_call = instr_word == CIES_OP_ACCCALL;
	assign is_decr = instr_word[15:10] == CIES_OP_DECR;
	assign is_move = instr_word[15:8] == CIES_OP_MOVE1
		&& !instr_word[7];

	// File address resolution for byte-oriented access
	always_comb begin
		dec_addr = {bank_select_reg, instr_word[7:0]};
		if (!instr_word[CIES_ACC_BIT]) begin
			if (ext_set_en && instr_word[7:0] <= CIES_IDX_LIMIT) begin
				// Indexed literal offset from the third pointer
				dec_addr = third_file_select_pointer
					+ {4'h0, instr_word[7:0]};
			end else if (instr_word[7:0] < CIES_ACCESS_SPLIT) begin
				dec_addr = {4'h0, instr_word[7:0]};
			end else begin
				dec_addr = {CIES_ACCESS_HI, instr_word[7:0]};
			end
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	assign instr_ready = state_ff == CIES_ST_FETCH
		|| state_ff == CIES_ST_MOVE2;
	assign busy = state_ff != CIES_ST_FETCH;

	// Next state; move waits for its second word
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			CIES_ST_FETCH: begin
				if (instr_valid && (is_decr || is_move)) begin
					nxt_state = is_move ? CIES_ST_MOVE2 : CIES_ST_EXEC;
				end else if (instr_valid && is_call) begin
					nxt_state = CIES_ST_CALL2;
				end
			end
			CIES_ST_EXEC: begin
				// Stay until the memory's answer has been used
				if (data_due_ff) begin
					nxt_state = CIES_ST_FETCH;
				end
			end
			CIES_ST_CALL2: begin
				nxt_state = CIES_ST_FETCH;
			end
			CIES_ST_MOVE2: begin
				if (instr_valid) begin
					nxt_state = CIES_ST_EXEC;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_ff <= CIES_ST_FETCH;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Latched opcode and resolved address
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			op_ff   <= 16'h0000;
			addr_ff <= 12'h000;
		end else if (state_ff == CIES_ST_FETCH && instr_valid) begin
			op_ff   <= instr_word;
			// Full 12-bit source reach, no bank folding
			addr_ff <= is_move ? third_file_select_pointer
				+ {5'h00, instr_word[6:0]} : dec_addr;
		end
	end

	// ****************************************************************
	// Data memory port
	// ****************************************************************
	logic           in_move;
	logic [11:0]    move_dst_ff;
	logic [7:0]     dec_res;
	logic           dec_nib_ok;

	assign in_move    = op_ff[15:8] == CIES_OP_MOVE1;
	assign dec_res    = dbus_rdata - 8'h01;
	assign dec_nib_ok = dbus_rdata[3:0] != 4'h0;

	// Memory registers rd, so its data stands one cycle after the pulse
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			data_due_ff <= 1'b0;
		end else begin
			data_due_ff <= dbus_ff.rd;
		end
	end

	assign exec_go = state_ff == CIES_ST_EXEC && data_due_ff;

	// Second move word holds the destination
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			move_dst_ff <= 12'h000;
		end else if (state_ff == CIES_ST_MOVE2 && instr_valid) begin
			move_dst_ff <= instr_word[11:0];
		end
	end

	// Read issues on entry, write follows once data is back unless a decrement targets the accumulator
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			dbus_ff <= '0;
		end else begin
			dbus_ff.rd <= nxt_state == CIES_ST_EXEC
				&& state_ff != CIES_ST_EXEC;
			dbus_ff.wr <= 1'b0;
			if (exec_go) begin
				dbus_ff.wr <= 1'b1;
				if (in_move) begin
					dbus_ff.addr  <= move_dst_ff;
					dbus_ff.wdata <= dbus_rdata;
				end else begin
					dbus_ff.wr    <= op_ff[CIES_DEST_BIT];
					dbus_ff.addr  <= addr_ff;
					dbus_ff.wdata <= dec_res;
				end
			end else if (state_ff != CIES_ST_EXEC
				&& nxt_state == CIES_ST_EXEC) begin
				// Decrement reads at once; addr_ff is not loaded yet
				dbus_ff.addr <= (state_ff == CIES_ST_MOVE2) ? addr_ff
					: dec_addr;
			end
		end
	end

	// ****************************************************************
	// Accumulator and flags
	// ****************************************************************
	logic [3:0] adj_lo;
	logic [4:0] hi_sum;
	logic [4:0] adj_hi;
	logic       adj_carry;

	// Decimal adjust arithmetic on the live accumulator
	always_comb begin
		adj_lo = accumulator_register_ff[3:0];
		if (accumulator_register_ff[3:0] > CIES_BCD_MAX || flags_ff.dcarry) begin
			adj_lo = accumulator_register_ff[3:0] + CIES_BCD_FIX;
		end
		hi_sum = {1'b0, accumulator_register_ff[7:4]} + {4'h0, flags_ff.dcarry};
		adj_hi = hi_sum;
		if (hi_sum > {1'b0, CIES_BCD_MAX} || flags_ff.carry) begin
			adj_hi = hi_sum + {1'b0, CIES_BCD_FIX};
		end
		// Carry is kept sticky so a carried BCD sum stays flagged
		adj_carry = adj_hi[4] || flags_ff.carry;
	end

	// Accumulator written by adjust and by decrement to accumulator
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			accumulator_register_ff <= 8'h00;
		end else if (state_ff == CIES_ST_FETCH && instr_valid && is_adj) begin
			accumulator_register_ff <= {adj_hi[3:0], adj_lo};
		end else if (exec_go && !in_move
			&& !op_ff[CIES_DEST_BIT]) begin
			accumulator_register_ff <= dec_res;
		end
	end

	// Flags; move and call leave them alone
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			flags_ff <= '0;
		end else if (state_ff == CIES_ST_FETCH && instr_valid && is_adj) begin
			flags_ff.carry <= adj_carry;
		end else if (exec_go && !in_move) begin
			flags_ff.carry  <= dbus_rdata != 8'h00;
			flags_ff.dcarry <= dec_nib_ok;
			flags_ff.neg    <= dec_res[7];
			flags_ff.ovf    <= dbus_rdata == 8'h80;
			flags_ff.zero   <= dec_res == 8'h00;
		end
	end

	// ****************************************************************
	// Program counter and return stack
	// ****************************************************************
	logic call_go;

	assign call_go = state_ff == CIES_ST_FETCH && instr_valid && is_call;

	// New target from accumulator and latches
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pc_ff      <= '0;
			pc_load_ff <= 1'b0;
		end else begin
			pc_load_ff <= call_go;
			if (call_go) begin
				pc_ff <= {counter_upper_latch, counter_high_latch,
					accumulator_register_ff};
			end
		end
	end

	cies_stack u_stack (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.push      (call_go),
		.push_data (pc_in + CIES_RET_STEP),
		.top_ff    (stack_top),
		.depth_ff  ()
	);

	// Flags moves aimed at counter low or stack top bytes
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			illegal_ff <= 1'b0;
		end else if (state_ff == CIES_ST_MOVE2 && instr_valid) begin
			illegal_ff <= instr_word[11:0] == CIES_ADDR_CNTLO
				|| (instr_word[11:0] >= CIES_ADDR_TOSLO
				&& instr_word[11:0] <= CIES_ADDR_TOSUP);
		end
	end

endmodule : cies_core
`default_nettype wire

// ---- logic/cies_pkg.sv ----
`default_nettype none
package cies_pkg;

	// ****************************************************************
	// Opcodes and field positions
	// ****************************************************************
	localparam logic [15:0] CIES_OP_DECADJ   = 16'h0007;
	localparam logic [15:0] CIES_OP_ACCCALL  = 16'h0014;
	localparam logic [5:0]  CIES_OP_DECR     = 6'h01;
	localparam logic [7:0]  CIES_OP_MOVE1    = 8'heb;
	localparam logic [3:0]  CIES_OP_MOVE2    = 4'hf;
	localparam int          CIES_DEST_BIT    = 9;
	localparam int          CIES_ACC_BIT     = 8;
	localparam logic [7:0]  CIES_IDX_LIMIT   = 8'h5f;
	localparam logic [7:0]  CIES_ACCESS_SPLIT = 8'h60;
	localparam logic [3:0]  CIES_BCD_MAX     = 4'h9;
	localparam logic [3:0]  CIES_BCD_FIX     = 4'h6;
	localparam logic [20:0] CIES_RET_STEP    = 21'h000002;
	localparam logic [3:0]  CIES_ACCESS_HI   = 4'hf;
	localparam int          CIES_DATA_AW     = 12;
	localparam int          CIES_PC_W        = 21;
	localparam int          CIES_STACK_DEPTH = 31;
	localparam logic [11:0] CIES_ADDR_CNTLO  = 12'hff9;
	localparam logic [11:0] CIES_ADDR_TOSLO  = 12'hffd;
	localparam logic [11:0] CIES_ADDR_TOSUP  = 12'hfff;

	// ****************************************************************
	// Status flags and bus records
	// ****************************************************************
	typedef struct packed {
		logic neg;
		logic ovf;
		logic zero;
		logic dcarry;
		logic carry;
	} cies_flags_type;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} cies_dbus_type;

	typedef enum logic [3:0] {
		CIES_ST_FETCH = 4'b0001,
		CIES_ST_EXEC  = 4'b0010,
		CIES_ST_CALL2 = 4'b0100,
		CIES_ST_MOVE2 = 4'b1000
	} cies_state_type;

endpackage : cies_pkg
`default_nettype wire

// ---- logic/cies_stack.sv ----
`default_nettype none
module cies_stack
	import cies_pkg::*;
(
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	// Push port
	input  wire logic                 push,
	input  wire logic [CIES_PC_W-1:0] push_data,
	// Top of stack
	output logic [CIES_PC_W-1:0]      top_ff,
	output logic [4:0]                depth_ff
);

	// ****************************************************************
	// Return address memory
	// ****************************************************************
	logic [CIES_PC_W-1:0] mem [CIES_STACK_DEPTH];

	// Entries hold no reset; only the pointer and top need one
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[depth_ff] <= push_data;
		end
	end

	// Registered top so the core sees a clean value
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			top_ff <= '0;
		end else if (push) begin
			top_ff <= push_data;
		end
	end

	// Pointer saturates rather than wrapping into live entries
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			depth_ff <= 5'h00;
		end else if (push && depth_ff != 5'(CIES_STACK_DEPTH - 1)) begin
			depth_ff <= depth_ff + 5'h01;
		end
	end

endmodule : cies_stack
`default_nettype wire

// ---- testbench/cies_core_checker.sv ----
`default_nettype none
module cies_core_checker
	import cies_pkg::*;
(
	// Clock and fetch
	input	wire logic	sys_clk,
	input	wire logic	reset,
	input	wire logic	instr_valid,
	input	wire logic [15:0]	instr_word,
	input	wire logic	instr_ready,
	// Memory and core context
	input	wire cies_dbus_type	dbus_ff,
	input	wire logic [7:0]	dbus_rdata,
	input	wire logic	ext_set_en,
	input	wire logic [3:0]	bank_select_reg,
	input	wire logic [11:0]	third_file_select_pointer,
	input	wire logic [7:0]	counter_high_latch,
	input	wire logic [4:0]	counter_upper_latch,
	input	wire logic [CIES_PC_W-1:0]	pc_in,
	// Architectural state
	input	wire logic [7:0]	accumulator_register_ff,
	input	wire cies_flags_type	flags_ff,
	input	wire logic [CIES_PC_W-1:0]	pc_ff,
	input	wire logic	pc_load_ff,
	input	wire logic [CIES_PC_W-1:0]	stack_top
);
	// ****************************************************************
	// Helper state
	// ****************************************************************
	logic	tk, mv_ff, d1_ff, d2_ff, dec_tk, adj_tk, call_tk, mv_tk;
	logic [6:0]	z_ff;
	assign tk = instr_valid & instr_ready;
	assign dec_tk = tk & !mv_ff & (instr_word[15:10] == CIES_OP_DECR);
	// A decrement two cycles back still writes flags: skip that overlap
	assign adj_tk = tk & !d2_ff & (instr_word == CIES_OP_DECADJ);
	assign call_tk = tk & !d2_ff & (instr_word == CIES_OP_ACCCALL);
	assign mv_tk = tk & mv_ff & (instr_word[15:12] == CIES_OP_MOVE2);
	// Offset of the first move word is needed one word later
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mv_ff <= 1'b0;
			z_ff <= 7'h00;
		end else if (tk) begin
			mv_ff <= instr_word[15:8] == CIES_OP_MOVE1;
			if (instr_word[15:8] == CIES_OP_MOVE1)
				z_ff <= instr_word[6:0];
		end
	end
	// Decrement age, for the flag overlap above
	always_ff @(posedge sys_clk) begin
		d1_ff <= dec_tk & !reset;
		d2_ff <= d1_ff & !reset;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// ****************************************************************
	// Properties
	// ****************************************************************
	dec_rd_a: assert property (
		dec_tk |=> dbus_ff.rd && !dbus_ff.wr)
		else $error("decrement read missing");
	bank_addr_a: assert property (
		dec_tk && instr_word[CIES_ACC_BIT] |=> dbus_ff.addr ==
		{$past(bank_select_reg), $past(instr_word[7:0])})
		else $error("banked address wrong");
	idx_addr_a: assert property (
		dec_tk && !instr_word[CIES_ACC_BIT] && ext_set_en &&
		instr_word[7:0] <= CIES_IDX_LIMIT |=> dbus_ff.addr ==
		$past(third_file_select_pointer) + {4'h0, $past(instr_word[7:0])})
		else $error("indexed address wrong");
	dec_res_a: assert property (
		dec_tk |-> ##3 (dbus_ff.wr == $past(instr_word[CIES_DEST_BIT], 3))
		&& (dbus_ff.wr ? dbus_ff.wdata : accumulator_register_ff) ==
		$past(dbus_rdata) - 8'h01)
		else $error("decrement result wrong");
	dec_flag_a: assert property (
		dec_tk |-> ##3 flags_ff.carry == ($past(dbus_rdata) != 8'h00) &&
		flags_ff.dcarry == ($past(dbus_rdata[3:0]) != 4'h0) &&
		flags_ff.zero == ($past(dbus_rdata) == 8'h01))
		else $error("decrement flags wrong");
	adj_one_a: assert property (
		adj_tk |=> instr_ready && flags_ff[4:1] == $past(flags_ff[4:1]) &&
		(flags_ff.carry || !$past(flags_ff.carry)))
		else $error("adjust touched flags");
	call_tgt_a: assert property (
		call_tk |=> pc_load_ff && stack_top == $past(pc_in) + CIES_RET_STEP
		&& pc_ff == {$past(counter_upper_latch), $past(counter_high_latch),
		$past(accumulator_register_ff)})
		else $error("call target wrong");
	call_two_a: assert property (
		call_tk |=> !instr_ready && $stable(accumulator_register_ff) &&
		$stable(flags_ff) ##1 instr_ready)
		else $error("call length wrong");
	mv_rd_a: assert property (
		mv_tk |=> dbus_ff.rd && dbus_ff.addr ==
		$past(third_file_select_pointer) + {5'h00, z_ff})
		else $error("move source wrong");
	mv_wr_a: assert property (
		mv_tk |-> ##3 dbus_ff.wr && dbus_ff.addr == $past(instr_word[11:0], 3)
		&& dbus_ff.wdata == $past(dbus_rdata) && $stable(flags_ff))
		else $error("move write wrong");
	cover property (dec_tk);
	cover property (adj_tk);
	cover property (call_tk);
	cover property (mv_tk);
endmodule : cies_core_checker
bind cies_core cies_core_checker u_cies_core_checker (.sys_clk, .reset,
	.instr_valid, .instr_word, .instr_ready, .dbus_ff, .dbus_rdata,
	.ext_set_en, .bank_select_reg, .third_file_select_pointer,
	.counter_high_latch, .counter_upper_latch, .pc_in,
	.accumulator_register_ff, .flags_ff, .pc_ff, .pc_load_ff, .stack_top);
`default_nettype wire

// ---- testbench/tb.sv ----
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cies_pkg::*;
	// ****************************************************************
	// Signals and design
	// ****************************************************************
	logic	sys_clk, reset, instr_valid, instr_ready, ext_set_en;
	logic	pc_load_ff, busy, illegal_ff;
	logic [15:0]	instr_word;
	logic [7:0]	dbus_rdata, counter_high_latch, acc;
	logic [3:0]	bank_select_reg;
	logic [11:0]	third_file_select_pointer;
	logic [4:0]	counter_upper_latch;
	logic [CIES_PC_W-1:0]	pc_in, pc_ff, stack_top;
	cies_dbus_type	dbus_ff;
	cies_flags_type	flags_ff;
	int	err_total, checks;
	cies_core u_cies_core (.sys_clk, .reset, .instr_valid, .instr_word,
		.instr_ready, .dbus_ff, .dbus_rdata, .ext_set_en, .bank_select_reg,
		.third_file_select_pointer, .counter_high_latch, .counter_upper_latch,
		.pc_in, .accumulator_register_ff(acc), .flags_ff, .pc_ff,
		.pc_load_ff, .stack_top, .busy, .illegal_ff);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(string what, logic [20:0] exp, logic [20:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	task automatic step;
		@(posedge sys_clk);
		#1;
	endtask : step
	// Hold the word until taken; bounded so a stuck ready ends the run
	task automatic issue(logic [15:0] w);
		instr_valid = 1'b1;
		instr_word = w;
		for (int n = 0; instr_ready !== 1'b1; n++) begin
			if (n > 20) begin
				err_total++;
				finish_test();
			end
			step();
		end
		step();
		instr_valid = 1'b0;
	endtask : issue
	// Memory is only valid in the cycle after the read; inverse otherwise
	task automatic mem(logic [11:0] ra, logic [7:0] v, logic w,
		logic [11:0] wa, logic [7:0] wd);
		chk("busy", 1'b1, busy);
		chk("rd", 1'b1, dbus_ff.rd);
		chk("rd addr", ra, dbus_ff.addr);
		dbus_rdata = ~v;
		step();
		dbus_rdata = v;
		step();
		dbus_rdata = ~v;
		chk("wr", w, dbus_ff.wr);
		chk("idle", 1'b0, busy);
		if (w) begin
			chk("wr addr", wa, dbus_ff.addr);
			chk("wr data", wd, dbus_ff.wdata);
		end
	endtask : mem
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_dec;
		// Clean accumulator and flags: neither nibble may be adjusted
		issue(CIES_OP_DECADJ);
		chk("adj idle", 8'h00, acc);
		chk("adj idle flags", 5'b00000, flags_ff);
		bank_select_reg = 4'h2;
		issue({CIES_OP_DECR, 2'b11, 8'h20});
		mem(12'h220, 8'h01, 1'b1, 12'h220, 8'h00);
		chk("flags zero", 5'b00111, flags_ff);
		issue({CIES_OP_DECR, 2'b10, 8'h30});
		mem(12'h030, 8'h10, 1'b1, 12'h030, 8'h0f);
		chk("flags nibble", 5'b00001, flags_ff);
		ext_set_en = 1'b1;
		third_file_select_pointer = 12'h300;
		issue({CIES_OP_DECR, 2'b10, 8'h10});
		mem(12'h310, 8'h80, 1'b1, 12'h310, 8'h7f);
		chk("flags ovf", 5'b01001, flags_ff);
		issue({CIES_OP_DECR, 2'b00, 8'h70});
		mem(12'hf70, 8'h00, 1'b0, 12'h000, 8'h00);
		chk("acc", 8'hff, acc);
		chk("flags borrow", 5'b10000, flags_ff);
		$display("test decrement done");
	endtask : t_dec
	task automatic t_adj;
		issue({CIES_OP_DECR, 2'b00, 8'h60});
		mem(12'hf60, 8'h25, 1'b0, 12'h000, 8'h00);
		issue(CIES_OP_DECADJ);
		chk("adj acc", 8'h9a, acc);
		chk("adj flags", 5'b00011, flags_ff);
		chk("adj ready", 1'b1, instr_ready);
		issue(16'h0000);
		chk("unknown", 8'h9a, acc);
		$display("test adjust done");
	endtask : t_adj
	task automatic t_call;
		counter_high_latch = 8'h10;
		counter_upper_latch = 5'h01;
		pc_in = 21'h001000;
		issue(CIES_OP_ACCCALL);
		chk("load", 1'b1, pc_load_ff);
		chk("target", 21'h01109a, pc_ff);
		chk("return", 21'h001002, stack_top);
		chk("call ready", 1'b0, instr_ready);
		chk("call busy", 1'b1, busy);
		chk("call acc", 8'h9a, acc);
		step();
		chk("load end", 1'b0, pc_load_ff);
		chk("busy end", 1'b0, busy);
		chk("ready back", 1'b1, instr_ready);
		$display("test call done");
	endtask : t_call
	// Move from pointer plus offset to a given destination; the first run puts both ends at the data space limits
	task automatic t_mv(logic [11:0] p, logic [6:0] z, logic [11:0] d,
		logic bad);
		third_file_select_pointer = p;
		issue({CIES_OP_MOVE1, 1'b0, z});
		step();
		issue({CIES_OP_MOVE2, d});
		mem(p + {5'h00, z}, 8'h5a, 1'b1, d, 8'h5a);
		chk("mv flags", 5'b00011, flags_ff);
		chk("forbidden", bad, illegal_ff);
		$display("test move done");
	endtask : t_mv
	initial begin
		reset = 1'b1;
		instr_valid = 1'b0;
		instr_word = 16'h0000;
		dbus_rdata = 8'h00;
		ext_set_en = 1'b0;
		bank_select_reg = 4'h0;
		third_file_select_pointer = 12'h000;
		counter_high_latch = 8'h00;
		counter_upper_latch = 5'h00;
		pc_in = 21'h000000;
		err_total = 0;
		checks = 0;
		repeat (12) @(posedge sys_clk);
		#1 reset = 1'b0;
		t_dec();
		t_adj();
		t_call();
		t_mv(12'hf80, 7'h7f, 12'h000, 1'b0);
		t_mv(12'h080, 7'h05, 12'hffd, 1'b1);
		finish_test();
	end
endmodule : tb
`default_nettype wire
